// ### rtl/wff_pkg.sv
// Constants for the wakeup-frame pattern filter: port layout, register map and reset values.
// Assumes a 32-bit AXI4-Lite register bus and a byte-wide receive stream on the same clock.
package wff_pkg;

  // ----------------------------------------------------------------
  // Filter port sequence
  // ----------------------------------------------------------------
  localparam int unsigned FILTERS = 8;
  localparam int unsigned PORT_WORDS = 40;
  localparam logic [5:0] CMD_BASE = 6'h20;
  localparam logic [5:0] OFS_BASE = 6'h22;
  localparam logic [5:0] CRC_BASE = 6'h24;
  localparam logic [5:0] LAST_WORD = 6'h27;
  localparam logic [31:0] CMD_KEEP_MASK = 32'h0f0f0f0f;
  localparam logic [31:0] PORT_WORD_RST = 32'h00000000;
  localparam int unsigned CMD_EN_BIT = 0;
  localparam int unsigned CMD_TYPE_LSB = 2;
  localparam logic [1:0] TYPE_UNICAST = 2'h0;
  localparam logic [1:0] TYPE_MULTICAST = 2'h2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] PORT_ADDR = 5'h00;
  localparam logic [4:0] PTR_ADDR = 5'h04;
  localparam logic [4:0] CTRL_ADDR = 5'h08;
  localparam logic [4:0] IRQ_STAT_ADDR = 5'h0c;
  localparam logic [4:0] IRQ_MASK_ADDR = 5'h10;
  localparam int unsigned DETECT_EN_BIT = 0;
  localparam int unsigned SEEN_BIT = 1;
  localparam int unsigned POWER_BIT = 4;
  localparam int unsigned UCAST_EN_BIT = 9;
  localparam int unsigned HIT_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // CRC-16 and frame position
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [8:0] POS_MAX = 9'h1ff;
  localparam logic [8:0] MASK_SPAN = 9'h080;

endpackage

// ### rtl/wake_frame_pattern_filter.sv
// Eight-entry wakeup-frame pattern filter with its AXI4-Lite register slave.
// Assumes the receive byte stream runs on i_sys_clk and marks frame start, end and address class.
`timescale 1ns/100ps

// What this block does
// - Mask bit j set puts frame byte offset+j into the CRC; clear skips it.
// - Each 128-bit mask is four words; word k covers bits 32k+31 down to 32k.
// - Within a mask word the lowest bit picks the earliest byte on the wire.
// - Port sequence is filter 0..7 mask words, then command, offset and CRC words.
// - Offsets packed four per word, filter 0 lowest byte; second word holds 4..7.
// - Each filter takes part in detection only if its command enables it; broadcast, and unicast with UCAST_EN_BIT set, pass any type.
// - Command bit 0 enables; bits 3:2 pick unicast, multicast or any passed frame.
// - Offset byte locates the first examined byte; zero is first destination byte.
// - CRC-16 over masked bytes equal to the stored value marks a wakeup frame.
// - With detection on, a match sets the seen flag, powers up and signals wakeup.
module wake_frame_pattern_filter (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [4:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [4:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_sof,
  input wire logic i_rx_eof,
  input wire logic i_rx_good,
  input wire logic i_rx_multicast,
  input wire logic i_rx_broadcast,
  input wire logic i_rx_pass_filter,
  output logic o_rx_normal_off,
  output logic o_remote_wakeup,
  output logic o_resume_power,
  output logic o_irq
);
  import wff_pkg::*;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [31:0] port_q [PORT_WORDS];
  logic [5:0] ptr_q;
  logic [31:0] ctrl_q;
  logic irq_stat_q;
  logic irq_mask_q;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [4:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wake_q, wake_d;
  logic [FILTERS-1:0] hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic known_addr(input logic [4:0] a);
    return a == PORT_ADDR || a == PTR_ADDR || a == CTRL_ADDR || a == IRQ_STAT_ADDR || a == IRQ_MASK_ADDR;
  endfunction

  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire rd_fire = i_arvalid & o_arready;
  wire port_wr = wr_fire & (waddr_q == PORT_ADDR);
  wire port_rd = rd_fire & (i_araddr == PORT_ADDR);
  wire [5:0] ptr_next = (ptr_q == LAST_WORD) ? 6'h00 : ptr_q + 6'h01;
  wire [31:0] port_keep = (ptr_q == CMD_BASE || ptr_q == CMD_BASE + 6'h01) ? CMD_KEEP_MASK : 32'hffffffff;
  wire [31:0] port_wval = merge(port_q[ptr_q], wdata_q, wstrb_q) & port_keep;
  wire [31:0] ctrl_wval = merge(ctrl_q, wdata_q, wstrb_q);
  wire ctrl_wr = wr_fire & (waddr_q == CTRL_ADDR);
  wire seen_clr = ctrl_wr & wstrb_q[0] & wdata_q[SEEN_BIT];
  wire stat_rd = rd_fire & (i_araddr == IRQ_STAT_ADDR);
  wire [31:0] rd_mux =
    (i_araddr == PORT_ADDR) ? port_q[ptr_q] :
    (i_araddr == PTR_ADDR) ? {26'h0, ptr_q} :
    (i_araddr == CTRL_ADDR) ? ctrl_q :
    (i_araddr == IRQ_STAT_ADDR) ? {31'h0, irq_stat_q} :
    (i_araddr == IRQ_MASK_ADDR) ? {31'h0, irq_mask_q} : 32'h00000000;

  assign o_awready = ~aw_held_q & ~bvalid_q;
  assign o_wready = ~w_held_q & ~bvalid_q;
  // A read waits one cycle behind a write so the port pointer never moves twice at once.
  assign o_arready = ~rvalid_q & ~wr_fire;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_q <= 1'b1;
        waddr_q <= i_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= known_addr(waddr_q) ? RESP_OKAY : RESP_DECERR;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= known_addr(i_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Filter port storage and pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      for (int k = 0; k < PORT_WORDS; k++) begin
        port_q[k] <= PORT_WORD_RST;
      end
    end else if (port_wr) begin
      port_q[ptr_q] <= port_wval;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ptr_q <= 6'h00;
    end else if (port_wr || port_rd) begin
      ptr_q <= ptr_next;
    end else if (wr_fire && waddr_q == PTR_ADDR) begin
      ptr_q <= (wdata_q[5:0] > LAST_WORD) ? 6'h00 : wdata_q[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Control, status and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= 32'h00000000;
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
      ctrl_q[DETECT_EN_BIT] <= ctrl_wr ? ctrl_wval[DETECT_EN_BIT] : ctrl_q[DETECT_EN_BIT];
      ctrl_q[UCAST_EN_BIT] <= ctrl_wr ? ctrl_wval[UCAST_EN_BIT] : ctrl_q[UCAST_EN_BIT];
      // A new wake in the clearing cycle keeps the flag set.
      ctrl_q[SEEN_BIT] <= wake_d | (ctrl_q[SEEN_BIT] & ~seen_clr);
      ctrl_q[POWER_BIT] <= wake_d | (ctrl_q[POWER_BIT] & ctrl_q[DETECT_EN_BIT]);
      ctrl_q[HIT_LSB +: FILTERS] <= wake_d ? hit : ctrl_q[HIT_LSB +: FILTERS];
      irq_stat_q <= wake_d | (irq_stat_q & ~stat_rd);
      if (wr_fire && waddr_q == IRQ_MASK_ADDR && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[0];
      end
    end
  end

  assign o_rx_normal_off = ctrl_q[DETECT_EN_BIT];
  assign o_remote_wakeup = wake_q;
  assign o_resume_power = ctrl_q[POWER_BIT];
  assign o_irq = irq_stat_q & irq_mask_q;

  // ----------------------------------------------------------------
  // Frame position and per-filter CRC
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int b = 0; b < 8; b++) begin
      c = (c[15] ^ data[b]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  logic [8:0] pos_q;
  logic [15:0] crc_q [FILTERS];
  wire [8:0] byte_idx = i_rx_sof ? 9'h000 : pos_q;
  wire is_unicast = ~i_rx_multicast & ~i_rx_broadcast;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pos_q <= 9'h000;
    end else if (i_rx_valid) begin
      pos_q <= (byte_idx == POS_MAX) ? POS_MAX : byte_idx + 9'h001;
    end
  end

  for (genvar f = 0; f < FILTERS; f++) begin : g_filter
    wire [127:0] mask_w = {port_q[4*f+3], port_q[4*f+2], port_q[4*f+1], port_q[4*f]};
    wire [7:0] ofs_w = port_q[OFS_BASE + 6'(f/4)][8*(f%4) +: 8];
    wire [3:0] cmd_w = port_q[CMD_BASE + 6'(f/4)][8*(f%4) +: 4];
    wire [15:0] exp_w = port_q[CRC_BASE + 6'(f/2)][16*(f%2) +: 16];
    wire [8:0] rel_w = byte_idx - {1'h0, ofs_w};
    wire [1:0] type_w = cmd_w[CMD_TYPE_LSB +: 2];
    // The lowest mask bit is the byte at the offset itself, the first of the span to arrive.
    wire take_w = i_rx_valid && byte_idx >= {1'h0, ofs_w} && rel_w < MASK_SPAN && mask_w[rel_w[6:0]];
    wire type_ok = i_rx_broadcast
      | (is_unicast & ctrl_q[UCAST_EN_BIT])
      | (i_rx_pass_filter & type_w[0])
      | (i_rx_pass_filter & type_w == TYPE_MULTICAST & i_rx_multicast)
      | (i_rx_pass_filter & type_w == TYPE_UNICAST & is_unicast);
    assign hit[f] = cmd_w[CMD_EN_BIT] & (crc_q[f] == exp_w) & type_ok;

    always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
        crc_q[f] <= CRC_INIT;
      end else if (i_rx_valid && i_rx_sof) begin
        crc_q[f] <= take_w ? crc16_byte(CRC_INIT, i_rx_data) : CRC_INIT;
      end else if (take_w) begin
        crc_q[f] <= crc16_byte(crc_q[f], i_rx_data);
      end
    end
  end

  assign wake_d = i_rx_eof & i_rx_good & ctrl_q[DETECT_EN_BIT] & (|hit);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  wake_pulse_a: assert property (wake_d |=> o_remote_wakeup && ctrl_q[SEEN_BIT] && o_resume_power)
    else $error("wake did not raise flag, power and wakeup");
  wake_cause_a: assert property (o_remote_wakeup |-> $past(ctrl_q[DETECT_EN_BIT]) && $past(i_rx_eof))
    else $error("wakeup without enabled frame end");
  seen_set_wins_a: assert property (wake_d && seen_clr |=> ctrl_q[SEEN_BIT])
    else $error("seen flag lost to clear");
  ptr_wrap_a: assert property ((port_wr || port_rd) && ptr_q == LAST_WORD |=> ptr_q == 6'h00)
    else $error("port pointer did not wrap after last word");
  ptr_step_a: assert property (port_wr && ptr_q < LAST_WORD |=> ptr_q == $past(ptr_q) + 6'h01)
    else $error("port pointer did not advance");
  cmd_reserved_a: assert property (port_q[CMD_BASE][7:4] == 4'h0 && port_q[CMD_BASE + 6'h01][31:28] == 4'h0)
    else $error("reserved command nibble stored");
  hit_disabled_a: assert property (!port_q[CMD_BASE][CMD_EN_BIT] |-> !hit[0])
    else $error("disabled filter matched");
  crc_hold_a: assert property (!i_rx_valid |=> crc_q[0] == $past(crc_q[0]))
    else $error("crc moved without a byte");
  crc_skip_a: assert property (i_rx_valid && !i_rx_sof && !g_filter[0].take_w |=> $stable(crc_q[0]))
    else $error("masked-out byte entered crc");
  bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  irq_level_a: assert property (o_irq == (irq_stat_q && irq_mask_q))
    else $error("interrupt level mismatch");

  wake_seen_c: cover property (wake_d ##1 o_irq);
  port_wrap_c: cover property (port_wr && ptr_q == LAST_WORD);
  crc_take_c: cover property (g_filter[0].take_w ##[1:20] i_rx_eof && hit[0]);
  decerr_c: cover property (o_bvalid && o_bresp == RESP_DECERR);

endmodule

// ### tb/rx_frame_source.sv
// Receive-side partner: plays byte frames into the filter with class flags at the end pulse.
// Assumes the filter samples everything on the rising edge of the shared clock.
`timescale 1ns/100ps
module rx_frame_source (
  input wire logic i_sys_clk,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_sof,
  output logic o_eof,
  output logic o_good,
  output logic [2:0] o_cls
);
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_sof = 1'b0;
    o_eof = 1'b0;
    o_good = 1'b0;
    o_cls = 3'h0;
  end
  // Between frames the data and class lines carry inverted garbage, never a held value.
  task automatic send(input logic [7:0] f[$], input logic [2:0] cls);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge i_sys_clk);
      o_valid <= 1'b1;
      o_data <= f[i];
      o_sof <= (i == 0);
    end
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    o_sof <= 1'b0;
    o_data <= ~f[f.size() - 1];
    o_eof <= 1'b1;
    o_good <= 1'b1;
    o_cls <= cls;
    @(posedge i_sys_clk);
    o_eof <= 1'b0;
    o_good <= 1'b0;
    o_cls <= ~cls;
  endtask
endmodule

// ### tb/wake_frame_pattern_filter_tb.sv
// Self-checking bench for the wake pattern filter: register bus tasks, frame stimulus, queue checker.
// Assumes the receive partner model and the package constants for the register map.
`timescale 1ns/100ps
module wake_frame_pattern_filter_tb;
  import wff_pkg::*;
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_sof, rx_eof, rx_good;
  logic normal_off, wake, power, irq;
  logic [7:0] rx_data;
  logic [2:0] rx_cls;
  logic [33:0] exp_q[$];
  int miscompares = 0, n_compared = 0, wake_cnt = 0, n_wake = 0;

  wake_frame_pattern_filter dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(1'b1), .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_sof(rx_sof), .i_rx_eof(rx_eof),
    .i_rx_good(rx_good), .i_rx_multicast(rx_cls[2]), .i_rx_broadcast(rx_cls[1]),
    .i_rx_pass_filter(rx_cls[0]), .o_rx_normal_off(normal_off), .o_remote_wakeup(wake),
    .o_resume_power(power), .o_irq(irq));
  rx_frame_source src (.i_sys_clk(i_sys_clk), .o_valid(rx_valid), .o_data(rx_data), .o_sof(rx_sof),
    .o_eof(rx_eof), .o_good(rx_good), .o_cls(rx_cls));

  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Response checker
  // ----------------------------------------------------------------
  // Ready lines are tied high, so each response is taken at the first edge it is seen.
  always @(posedge i_sys_clk) begin
    if (rvalid === 1'b1) chk({rresp, rdata}, exp_q.pop_front());
    if (bvalid === 1'b1) chk({bresp, 32'h0}, exp_q.pop_front() & 34'h300000000);
    if (wake === 1'b1) wake_cnt++;
  end

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
  endtask

  // Bit-serial reference, lsb of each selected byte first into the top of the shift register.
  function automatic logic [15:0] crc_of(input logic [7:0] fr[$], input logic [127:0] m, input logic [7:0] o);
    logic [15:0] c;
    logic fb;
    c = CRC_INIT;
    for (int p = o; p < fr.size() && p < o + 128; p++) begin
      if (m[p - o]) begin
        for (int b = 0; b < 8; b++) begin
          fb = c[15] ^ fr[p][b];
          c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
      end
    end
    return c;
  endfunction

  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] pw[40];
    logic [7:0] fr[$], hit, last_hit, o;
    logic [127:0] m;
    logic [3:0] cmd;
    logic [15:0] c;
    logic mc, bc, pass, gu, ok, w;
    void'($urandom(32'hbe28));
    last_hit = 8'h00;
    repeat (4) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    rd(CTRL_ADDR, {RESP_OKAY, PORT_WORD_RST});
    rd(PORT_ADDR, {RESP_OKAY, PORT_WORD_RST});
    rd(PTR_ADDR, {RESP_OKAY, 32'h00000001});
    rd(5'h14, {RESP_DECERR, 32'h0});
    wr(5'h18, 32'hffffffff, RESP_DECERR);
    wr(PTR_ADDR, 32'h00000030, RESP_OKAY);
    rd(PTR_ADDR, {RESP_OKAY, 32'h0});
    for (int it = 0; it < 6; it++) begin
      for (int i = 0; i < 40; i++) pw[i] = $urandom;
      pw[34] &= 32'h0f0f0f0f;
      pw[35] &= 32'h0f0f0f0f;
      fr = {};
      for (int i = 0; i < 48; i++) fr.push_back(8'($urandom));
      c = 16'($urandom % 3);
      mc = (c == 1);
      bc = (c == 2);
      pass = 1'($urandom);
      gu = 1'($urandom);
      hit = 8'h00;
      for (int f = 0; f < 8; f++) begin
        m = {pw[4 * f + 3], pw[4 * f + 2], pw[4 * f + 1], pw[4 * f]};
        o = pw[34 + f / 4][8 * (f % 4) +: 8];
        cmd = pw[32 + f / 4][8 * (f % 4) +: 4];
        ok = ($urandom % 4) != 0;
        pw[36 + f / 2][16 * (f % 2) +: 16] = crc_of(fr, m, o) ^ {15'h0, !ok};
        hit[f] = cmd[0] && ok && (bc || (!mc && !bc && gu) || (pass && cmd[2])
          || (pass && cmd[3:2] == 2'h2 && mc) || (pass && cmd[3:2] == 2'h0 && !mc && !bc));
      end
      wr(PTR_ADDR, 32'h0, RESP_OKAY);
      for (int i = 0; i < 40; i++) wr(PORT_ADDR, pw[i], RESP_OKAY);
      wr(PTR_ADDR, 32'h0, RESP_OKAY);
      for (int i = 0; i < 40; i++) rd(PORT_ADDR, {RESP_OKAY, pw[i] & ((i / 2 == 16) ? CMD_KEEP_MASK : '1)});
      wr(IRQ_MASK_ADDR, {31'h0, it[0]}, RESP_OKAY);
      wr(CTRL_ADDR, {22'h0, gu, 9'h001}, RESP_OKAY);
      chk({33'h0, normal_off}, 34'h1);
      src.send(fr, {mc, bc, pass});
      repeat (2) @(posedge i_sys_clk);
      w = |hit;
      if (w) last_hit = hit;
      n_wake += w;
      chk({33'h0, irq}, {33'h0, w & it[0]});
      chk({33'h0, power}, {33'h0, w});
      rd(CTRL_ADDR, {RESP_OKAY, 8'h0, last_hit, 6'h0, gu, 4'h0, w, 2'h0, w, 1'b1});
      rd(IRQ_STAT_ADDR, {RESP_OKAY, 31'h0, w});
      rd(IRQ_STAT_ADDR, {RESP_OKAY, 32'h0});
      wr(CTRL_ADDR, 32'h00000002, RESP_OKAY);
      @(posedge i_sys_clk);
      chk({32'h0, power, normal_off}, 34'h0);
    end
    repeat (2) @(posedge i_sys_clk);
    chk(34'(wake_cnt), 34'(n_wake));
    finish_test();
  end
endmodule
